// ### design/dasi_conv_timer.sv
// conversion timer paced by the internal oscillator divider
`timescale 1ns/1ps
module dasi_conv_timer import dasi_pkg::*; #(
  parameter int DIV = OSC_DIV,
  parameter int TICKS = CONV_TICKS
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);
  if (DIV < 1 || DIV > 255 || TICKS < 1 || TICKS > 255) begin : g_chk
    $error("dasi_conv_timer divider or tick count out of range");
  end
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [7:0] TICK_LAST = 8'(TICKS - 1);
  dasi_conv_t state_reg;
  logic [7:0] div_reg;
  logic [7:0] tick_reg;
  logic done_reg;
  wire osc_tick = (div_reg == DIV_LAST);
  // oscillator runs free; the serial clock never enters here
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= osc_tick ? 8'h00 : div_reg + 8'h01;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= C_IDLE;
      tick_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        C_IDLE: begin
          if (i_start) begin
            state_reg <= C_CONV;
            tick_reg <= 8'h00;
          end
        end
        C_CONV: begin
          if (i_start) begin
            tick_reg <= 8'h00;
          end else if (osc_tick) begin
            if (tick_reg == TICK_LAST) begin
              state_reg <= C_IDLE;
              done_reg <= 1'b1;
            end else begin
              tick_reg <= tick_reg + 8'h01;
            end
          end
        end
        default: state_reg <= C_IDLE;
      endcase
    end
  end
  assign o_busy = (state_reg == C_CONV);
  assign o_done = done_reg;
endmodule : dasi_conv_timer

// ### design/dasi_pkg.sv
// constants, types and helpers of the dual converter serial interface
// Operation
// - ref select 0 internal buffer, 1 external pin
// - reset field bits 7..0 of second config
// - soft reset keeps config, reinits interface state
// - hard reset also restores defaults, resets oscillator
// - self test after reset flags setup fail
// - chip select fall samples, converts, drives outputs
// - conversion timed by internal oscillator only
// - results of one conversion read next frame
// - result width 16 or 14 without boost
// - msb at select fall, shift on rising clock
// - select rise releases both outputs
// - frame length from lanes, boost and checksum
// - two lanes: A on first, B on second
// - one lane: A then B on first output
// - boost with oversampling adds two bits
// - second pulse after conversion reads its result
// - read command bit15 0, address 14..12
// - read data returned in following frame
// - write command bit15 1, twelve data bits
// - write access 16 bits, 24 with checksum
// - read checksum appended on first output
// - checksum polynomial x8+x2+x+1
package dasi_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CFG1 = 3'h1;
  localparam logic [2:0] ADDR_CFG2 = 3'h2;
  localparam logic [2:0] ADDR_ALERT = 3'h3;
  localparam int C1_CRC_R = 0;
  localparam int C1_CRC_W = 1;
  localparam int C1_REF_SEL = 2;
  localparam int C1_RES = 6;
  localparam int C1_OSR_LSB = 9;
  localparam int C2_LANE = 8;
  localparam int AL_SETUP_F = 11;
  localparam logic [11:0] CFG1_DEFAULT = 12'h000;
  localparam logic [11:0] CFG2_DEFAULT = 12'h000;
  localparam logic [11:0] CFG2_STORE_MASK = 12'hf00;
  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam logic [6:0] CMD_BITS = 7'h10;
  localparam logic [6:0] CMD_CRC_BITS = 7'h18;
  localparam logic [6:0] CRC_BITS = 7'h08;
  localparam logic [6:0] WORD_BITS = 7'h40;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_CONVERT_NS = 190;
  localparam int OSC_DIV = 2;
  localparam int CONV_TICKS = (T_CONVERT_NS + CLK_PERIOD_NS * OSC_DIV - 1) / (CLK_PERIOD_NS * OSC_DIV);
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } dasi_pins_t;
  typedef struct packed {
    logic is_write;
    logic [2:0] addr;
    logic [11:0] data;
  } dasi_cmd_t;
  typedef enum logic [1:0] {F_IDLE = 2'b01, F_ACTIVE = 2'b10} dasi_frame_t;
  typedef enum logic [1:0] {C_IDLE = 2'b01, C_CONV = 2'b10} dasi_conv_t;
  // serial form: preset ones equals inverting the first eight data bits
  function automatic logic [7:0] dasi_crc8(input logic [63:0] d, input logic [6:0] len);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    fb = 1'b0;
    for (int i = 0; i < 64; i++) begin
      if (7'(i) < len) begin
        fb = c[7] ^ d[63-i];
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction : dasi_crc8
endpackage : dasi_pkg

// ### design/dasi_serial_if.sv
// serial interface and control logic of the dual converter
`timescale 1ns/1ps
module dasi_serial_if import dasi_pkg::*; #(
  parameter int RES = 16,
  parameter logic [7:0] SOFT_CODE = 8'h3c,
  parameter logic [7:0] HARD_CODE = 8'hff
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic [RES+1:0] i_adc_a,
  input wire logic [RES+1:0] i_adc_b,
  input wire logic i_cfg_check_fail,
  output logic o_sdo_a,
  output logic o_sdo_a_oe,
  output logic o_sdo_b,
  output logic o_sdo_b_oe,
  output logic o_sample,
  output logic o_conv_busy,
  output logic o_ref_buf_en,
  output logic o_soft_reset,
  output logic o_hard_reset,
  output logic o_setup_fail,
  output logic o_boost,
  output logic [2:0] o_osr
);
  if (RES != 16 && RES != 14) begin : g_chk
    $error("dasi_serial_if supports resolutions 16 and 14 only");
  end
  // equal codes could not tell a soft reset from a hard one
  if (SOFT_CODE == HARD_CODE) begin : g_code_chk
    $error("dasi_serial_if reset codes must differ");
  end
  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  dasi_pins_t pins;
  dasi_pins_t pins_prev_reg;
  dasi_sync #(.W(3)) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_cs_n, i_sclk, i_sdi}),
    .i_idle(3'h4),
    .o_sync(pins)
  );
  // reset value equals the idle pin levels, so no false edge follows reset
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pins_prev_reg <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
    end else begin
      pins_prev_reg <= pins;
    end
  end
  wire cs_fall = pins_prev_reg.cs_n & ~pins.cs_n;
  wire cs_rise = ~pins_prev_reg.cs_n & pins.cs_n;
  wire sclk_rise = ~pins_prev_reg.sclk & pins.sclk;
  wire sclk_fall = pins_prev_reg.sclk & ~pins.sclk;
  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  dasi_frame_t frame_reg;
  logic [11:0] cfg1_reg;
  logic [11:0] cfg2_reg;
  logic setup_f_reg;
  logic st_run_reg;
  logic sw_rst_reg;
  logic soft_reg;
  logic hard_reg;
  logic [6:0] cnt_reg;
  logic [23:0] rx_reg;
  logic rd_pend_reg;
  logic [2:0] rd_addr_reg;
  logic [63:0] sh_a_reg;
  logic [63:0] sh_b_reg;
  logic oe_a_reg;
  logic oe_b_reg;
  logic sample_reg;
  logic [RES+1:0] res_a_reg;
  logic [RES+1:0] res_b_reg;
  logic conv_done;
  logic conv_busy;
  wire active = (frame_reg == F_ACTIVE);
  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  wire crc_r = cfg1_reg[C1_CRC_R];
  wire crc_w = cfg1_reg[C1_CRC_W];
  wire [2:0] osr = cfg1_reg[C1_OSR_LSB +: 3];
  wire boost = cfg1_reg[C1_RES] & (osr != 3'h0);
  wire one_lane = cfg2_reg[C2_LANE];
  wire [6:0] rw = boost ? 7'(RES + 2) : 7'(RES);
  wire [6:0] dlen = 7'(rw << 1);
  // ----------------------------------------------------------------
  // conversion timing and result capture
  // ----------------------------------------------------------------
  // a software reset also restarts the timer and drops a conversion in flight
  dasi_conv_timer u_conv (
    .i_clock(i_clock),
    .i_rst(i_rst | sw_rst_reg),
    .i_start(cs_fall),
    .o_busy(conv_busy),
    .o_done(conv_done)
  );
  // results only change when a conversion ends, so a frame opened
  // before that still reads the previous sample
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      res_a_reg <= '0;
      res_b_reg <= '0;
    end else if (conv_done) begin
      res_a_reg <= i_adc_a;
      res_b_reg <= i_adc_b;
    end
  end
  // ----------------------------------------------------------------
  // output word assembly
  // ----------------------------------------------------------------
  wire [RES+1:0] a_sel = boost ? res_a_reg : (res_a_reg >> 2);
  wire [RES+1:0] b_sel = boost ? res_b_reg : (res_b_reg >> 2);
  wire [63:0] w_a = {{(62 - RES){1'b0}}, a_sel};
  wire [63:0] w_b = {{(62 - RES){1'b0}}, b_sel};
  wire [63:0] a_top = w_a << (WORD_BITS - rw);
  wire [63:0] b_top = w_b << (WORD_BITS - rw);
  wire [63:0] combo = a_top | (w_b << (WORD_BITS - dlen));
  // the checksum always covers both channels, whichever lanes carry them
  wire [7:0] crc_conv = dasi_crc8(combo, dlen);
  wire [63:0] crc_w64 = {56'h0, crc_conv};
  wire [63:0] crc_two = crc_r ? (crc_w64 << (WORD_BITS - rw - CRC_BITS)) : 64'h0;
  wire [63:0] crc_one = crc_r ? (crc_w64 << (WORD_BITS - dlen - CRC_BITS)) : 64'h0;
  wire [11:0] rd_data = (rd_addr_reg == ADDR_CFG1) ? cfg1_reg :
                        (rd_addr_reg == ADDR_CFG2) ? cfg2_reg :
                        {setup_f_reg, 11'h000};
  wire [15:0] rd_word = {1'b0, rd_addr_reg, rd_data};
  wire [63:0] rd_top = {rd_word, 48'h0};
  wire [7:0] crc_rd = dasi_crc8(rd_top, CMD_BITS);
  wire [63:0] rd_a = rd_top | (crc_r ? {16'h0, crc_rd, 40'h0} : 64'h0);
  wire [63:0] conv_a = one_lane ? (combo | crc_one) : (a_top | crc_two);
  wire [63:0] load_a = rd_pend_reg ? rd_a : conv_a;
  wire [63:0] load_b = (rd_pend_reg | one_lane) ? 64'h0 : b_top;
  // ----------------------------------------------------------------
  // command capture and decode
  // ----------------------------------------------------------------
  wire [4:0] rx_idx = 5'(5'd23 - cnt_reg[4:0]);
  wire [23:0] rx_bit = 24'(pins.sdi) << rx_idx;
  dasi_cmd_t cmd;
  assign cmd = rx_reg[23:8];
  wire [7:0] crc_cmd = dasi_crc8({rx_reg[23:8], 48'h0}, CMD_BITS);
  wire long_ok = (cnt_reg >= CMD_BITS);
  // a write that turns write checksums on must already carry a valid one
  wire need_crc = crc_w | ((cmd.addr == ADDR_CFG1) & cmd.data[C1_CRC_W]);
  wire crc_ok = (cnt_reg >= CMD_CRC_BITS) & (rx_reg[7:0] == crc_cmd);
  wire frame_end = active & cs_rise;
  wire wr_ok = frame_end & long_ok & cmd.is_write & (~need_crc | crc_ok);
  wire wr_cfg1 = wr_ok & (cmd.addr == ADDR_CFG1);
  wire wr_cfg2 = wr_ok & (cmd.addr == ADDR_CFG2);
  wire do_soft = wr_cfg2 & (cmd.data[7:0] == SOFT_CODE);
  wire do_hard = wr_cfg2 & (cmd.data[7:0] == HARD_CODE);
  wire rd_cmd = frame_end & long_ok & ~cmd.is_write;
  // an unmapped read leaves nothing pending, so the next frame carries results
  wire rd_mapped = (cmd.addr == ADDR_CFG1) | (cmd.addr == ADDR_CFG2) | (cmd.addr == ADDR_ALERT);
  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst | sw_rst_reg) begin
      frame_reg <= F_IDLE;
    end else begin
      case (frame_reg)
        F_IDLE: frame_reg <= cs_fall ? F_ACTIVE : F_IDLE;
        F_ACTIVE: frame_reg <= cs_rise ? F_IDLE : F_ACTIVE;
        default: frame_reg <= F_IDLE;
      endcase
    end
  end
  // serial input, first clock lands in bit 23
  always_ff @(posedge i_clock) begin
    if (i_rst | cs_fall) begin
      cnt_reg <= 7'h00;
      rx_reg <= 24'h0;
    end else if (active & sclk_fall) begin
      if (cnt_reg < CMD_CRC_BITS) begin
        rx_reg <= rx_reg | rx_bit;
      end
      if (cnt_reg != 7'h7f) begin
        cnt_reg <= cnt_reg + 7'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // msb appears at the select fall, later bits on rise
  always_ff @(posedge i_clock) begin
    if (i_rst | sw_rst_reg) begin
      sh_a_reg <= 64'h0;
      sh_b_reg <= 64'h0;
    end else if (cs_fall) begin
      sh_a_reg <= load_a;
      sh_b_reg <= load_b;
    end else if (active & ~cs_rise & sclk_rise) begin
      sh_a_reg <= {sh_a_reg[62:0], 1'b0};
      sh_b_reg <= {sh_b_reg[62:0], 1'b0};
    end
  end
  // enables follow the frame, B only with two lanes; a software reset releases both lanes
  always_ff @(posedge i_clock) begin
    if (i_rst | sw_rst_reg) begin
      oe_a_reg <= 1'b0;
      oe_b_reg <= 1'b0;
    end else if (cs_fall) begin
      oe_a_reg <= 1'b1;
      oe_b_reg <= ~one_lane;
    end else if (cs_rise) begin
      oe_a_reg <= 1'b0;
      oe_b_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // register read-back request
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst | sw_rst_reg) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 3'h0;
    end else if (rd_cmd) begin
      rd_pend_reg <= rd_mapped;
      rd_addr_reg <= cmd.addr;
    end else if (cs_fall) begin
      rd_pend_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // configuration registers and software resets
  // ----------------------------------------------------------------
  // the reset field is never stored, so it reads back as zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg1_reg <= CFG1_DEFAULT;
      cfg2_reg <= CFG2_DEFAULT;
    end else if (do_hard) begin
      cfg1_reg <= CFG1_DEFAULT;
      cfg2_reg <= CFG2_DEFAULT;
    end else if (wr_cfg1) begin
      cfg1_reg <= cmd.data;
    end else if (wr_cfg2 & ~do_soft) begin
      cfg2_reg <= cmd.data & CFG2_STORE_MASK;
    end
  end
  // reset pulses are registered so they land after the frame closes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sw_rst_reg <= 1'b0;
      soft_reg <= 1'b0;
      hard_reg <= 1'b0;
    end else begin
      sw_rst_reg <= do_soft | do_hard;
      soft_reg <= do_soft | do_hard;
      hard_reg <= do_hard;
    end
  end
  // self test runs once after power-on and after every hard reset;
  // a failure set in the same cycle as a clear still sticks
  wire st_set = st_run_reg & i_cfg_check_fail;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_run_reg <= 1'b1;
      setup_f_reg <= 1'b0;
    end else begin
      st_run_reg <= hard_reg;
      if (st_set) begin
        setup_f_reg <= 1'b1;
      end else if (soft_reg) begin
        setup_f_reg <= 1'b0;
      end
    end
  end
  // host is expected to follow a set flag with a hard reset
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sample_reg <= 1'b0;
      o_conv_busy <= 1'b0;
      o_ref_buf_en <= 1'b1;
      o_boost <= 1'b0;
      o_osr <= 3'h0;
    end else begin
      sample_reg <= cs_fall;
      o_conv_busy <= conv_busy;
      o_ref_buf_en <= ~cfg1_reg[C1_REF_SEL];
      o_boost <= boost;
      o_osr <= osr;
    end
  end
  assign o_sample = sample_reg;
  assign o_sdo_a = sh_a_reg[63];
  assign o_sdo_b = sh_b_reg[63];
  assign o_sdo_a_oe = oe_a_reg;
  assign o_sdo_b_oe = oe_b_reg;
  assign o_soft_reset = soft_reg;
  assign o_hard_reset = hard_reg;
  assign o_setup_fail = setup_f_reg;
endmodule : dasi_serial_if

// ### design/dasi_sync.sv
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module dasi_sync import dasi_pkg::*; #(
  parameter int W = 3
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  input wire logic [W-1:0] i_idle,
  output logic [W-1:0] o_sync
);
  if (W < 1) begin : g_chk
    $error("dasi_sync width must be positive");
  end
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  // idle value is a tie-off constant at the instance
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_reg <= i_idle;
      sync_reg <= i_idle;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule : dasi_sync

// ### verification/dasi_host_model.sv
// host controller model driving select, serial clock and serial input
`timescale 1ns/1ps
module dasi_host_model import dasi_pkg::*; #(
  parameter int HALF = 20
) (
  input wire logic i_clock,
  input wire logic i_sdo_a,
  input wire logic i_sdo_a_oe,
  input wire logic i_sdo_b,
  input wire logic i_sdo_b_oe,
  output dasi_pins_t o_pins
);
  logic last_a = 1'b0;
  logic last_b = 1'b0;
  initial o_pins = 3'h4;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  // whole access in one frame, since each select fall also starts a conversion
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] ra, output logic [63:0] rb);
    ra = '0;
    rb = '0;
    tick(1);
    o_pins.cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      tick(HALF);
      // a released lane reads as the inverse of its last level
      last_a = i_sdo_a_oe ? i_sdo_a : ~last_a;
      last_b = i_sdo_b_oe ? i_sdo_b : ~last_b;
      ra[63-i] = last_a;
      rb[63-i] = last_b;
      // data moves with the rise so it is settled at the fall that takes it
      o_pins.sdi = tx[63-i];
      o_pins.sclk = 1'b1;
      tick(HALF);
      o_pins.sclk = 1'b0;
    end
    tick(HALF);
    o_pins.cs_n = 1'b1;
    o_pins.sdi = ~o_pins.sdi;
    tick(2 * HALF);
  endtask : xfer
endmodule : dasi_host_model

// ### verification/dasi_serial_if_monitor.sv
// port-level checks of the dual converter serial interface
`timescale 1ns/1ps
module dasi_serial_if_monitor import dasi_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_cfg_check_fail,
  input wire logic o_sdo_a,
  input wire logic o_sdo_a_oe,
  input wire logic o_sdo_b_oe,
  input wire logic o_sample,
  input wire logic o_conv_busy,
  input wire logic o_ref_buf_en,
  input wire logic o_soft_reset,
  input wire logic o_hard_reset,
  input wire logic o_setup_fail,
  input wire logic o_boost,
  input wire logic [2:0] o_osr
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  localparam int CONV_MIN = CONV_TICKS * OSC_DIV - 2;
  localparam int CONV_MAX = CONV_TICKS * OSC_DIV + 2;
  logic [1:0] pin_reg;
  logic [7:0] busy_cnt;
  logic [7:0] edge_age;
  wire pin_edge = (pin_reg[1] && !i_cs_n) || (!pin_reg[0] && i_sclk);
  always_ff @(posedge i_clock) begin
    pin_reg <= {i_cs_n, i_sclk};
    busy_cnt <= (i_rst || !o_conv_busy) ? 8'h00 : busy_cnt + 8'h01;
    edge_age <= i_rst ? 8'hff : (pin_edge ? 8'h00 : edge_age + {7'h00, edge_age != 8'hff});
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_sample; $fell(i_cs_n) |-> ##[1:5] o_sample; endproperty
  a_sample: assert property (p_sample) else $error("no sample pulse after select fall");
  property p_oe_on; $fell(i_cs_n) |-> ##[1:6] o_sdo_a_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("first output not driven in frame");
  property p_oe_off; $rose(i_cs_n) |-> ##[1:6] (!o_sdo_a_oe && !o_sdo_b_oe); endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs not released after frame");
  property p_sample_busy; o_sample |-> ##[0:2] o_conv_busy; endproperty
  a_sample_busy: assert property (p_sample_busy) else $error("sample without conversion");
  property p_conv_len; $fell(o_conv_busy) |-> busy_cnt inside {[CONV_MIN:CONV_MAX]}; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_bit_hold; $changed(o_sdo_a) && o_sdo_a_oe && $past(o_sdo_a_oe) && !i_cs_n |-> edge_age <= 8'h07;
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("output bit moved without clock rise");
  property p_hard_soft; o_hard_reset |-> o_soft_reset; endproperty
  a_hard_soft: assert property (p_hard_soft) else $error("hard reset without soft part");
  property p_ref_default; o_hard_reset |-> ##[0:3] o_ref_buf_en; endproperty
  a_ref_default: assert property (p_ref_default) else $error("reference buffer not restored");
  property p_setup; $fell(i_rst) && i_cfg_check_fail |-> ##[0:3] o_setup_fail; endproperty
  a_setup: assert property (p_setup) else $error("self test failure not flagged");
  property p_boost; o_boost |-> o_osr != 3'h0; endproperty
  a_boost: assert property (p_boost) else $error("boost without oversampling");
  property p_lane_b; o_sdo_b_oe |-> o_sdo_a_oe; endproperty
  a_lane_b: assert property (p_lane_b) else $error("second lane driven alone");
endmodule : dasi_serial_if_monitor
bind dasi_serial_if dasi_serial_if_monitor u_mon (.i_clock(i_clock), .i_rst(i_rst), .i_cs_n(i_cs_n),
  .i_sclk(i_sclk), .i_cfg_check_fail(i_cfg_check_fail), .o_sdo_a(o_sdo_a), .o_sdo_a_oe(o_sdo_a_oe),
  .o_sdo_b_oe(o_sdo_b_oe), .o_sample(o_sample), .o_conv_busy(o_conv_busy), .o_ref_buf_en(o_ref_buf_en),
  .o_soft_reset(o_soft_reset), .o_hard_reset(o_hard_reset), .o_setup_fail(o_setup_fail),
  .o_boost(o_boost), .o_osr(o_osr));

// ### verification/dasi_serial_if_test.sv
// self-checking bench of the dual converter serial interface
`timescale 1ns/1ps
module dasi_serial_if_test import dasi_pkg::*;;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [17:0] adc_a = '0;
  logic [17:0] adc_b = '0;
  logic check_fail = 1'b1;
  logic sdo_a, sdo_a_oe, sdo_b, sdo_b_oe, ref_en, setup_fail, boost;
  dasi_pins_t pins;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0000_001e;
  logic [17:0] pa, pb;
  logic [63:0] ra, rb;
  initial forever #2 i_clock = ~i_clock;
  dasi_serial_if dut (.i_clock(i_clock), .i_rst(i_rst), .i_cs_n(pins.cs_n), .i_sclk(pins.sclk),
    .i_sdi(pins.sdi), .i_adc_a(adc_a), .i_adc_b(adc_b), .i_cfg_check_fail(check_fail), .o_sdo_a(sdo_a),
    .o_sdo_a_oe(sdo_a_oe), .o_sdo_b(sdo_b), .o_sdo_b_oe(sdo_b_oe), .o_sample(), .o_conv_busy(),
    .o_ref_buf_en(ref_en), .o_soft_reset(), .o_hard_reset(), .o_setup_fail(setup_fail), .o_boost(boost),
    .o_osr());
  dasi_host_model u_host (.i_clock(i_clock), .i_sdo_a(sdo_a), .i_sdo_a_oe(sdo_a_oe), .i_sdo_b(sdo_b),
    .i_sdo_b_oe(sdo_b_oe), .o_pins(pins));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] crc(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 0; i < n; i++) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[63-i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // every frame also converts, so the inputs it sampled are next frame's data
  task automatic cmd(input logic [15:0] w, input int n);
    u_host.xfer({w, crc({w, 48'h0}, 16), 40'h0}, n, ra, rb);
    pa = adc_a;
    pb = adc_b;
  endtask : cmd
  task automatic rd(input logic [2:0] a, input logic [11:0] d);
    cmd({1'b0, a, 12'(rnd())}, 16);
    cmd(16'h0000, 16);
    check(ra, {1'b0, a, d, 48'h0});
  endtask : rd
  task automatic conv(input bit one, input bit bst, input bit cr, input bit chk);
    int w;
    logic [63:0] da, db, ab, ea, mask;
    w = bst ? 18 : 16;
    da = bst ? {pa, 46'h0} : {pa[17:2], 48'h0};
    db = bst ? {pb, 46'h0} : {pb[17:2], 48'h0};
    ab = da | (db >> w);
    ea = one ? ab : da;
    if (cr) ea = ea | ({crc(ab, 2 * w), 56'h0} >> (one ? 2 * w : w));
    mask = ~(64'hffff_ffff_ffff_ffff >> w);
    adc_a = 18'(rnd());
    adc_b = 18'(rnd());
    cmd({4'h0, 12'(rnd())}, (one ? 2 * w : w) + (cr ? 8 : 0));
    if (chk) check(ra, ea);
    if (chk && !one) check(rb & mask, db);
  endtask : conv
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    cycles++;
    // a clean run needs about 51k cycles, so only a hang reaches this
    if (cycles == 80000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    u_host.tick(4);
    check(setup_fail, 1'b1);
    check_fail = 1'b0;
    rd(ADDR_ALERT, 12'h800);
    cmd(16'ha0ff, 16);
    check(setup_fail, 1'b0);
    cmd(16'h9004, 16);
    check(ref_en, 1'b0);
    cmd(16'ha03c, 16);
    check(ref_en, 1'b0);
    rd(ADDR_CFG1, 12'h004);
    cmd(16'ha0ff, 16);
    check(ref_en, 1'b1);
    rd(ADDR_CFG1, 12'h000);
    cmd(16'h9004, 12);
    check(ref_en, 1'b1);
    for (int m = 0; m < 8; m++) begin
      cmd({4'h9, (m[1] ? 12'h240 : 12'h000) | {11'h0, m[2]}}, 16);
      cmd({7'h50, m[0], 8'h00}, 16);
      check(boost, m[1]);
      conv(m[0], m[1], m[2], 1'b0);
      conv(m[0], m[1], m[2], 1'b1);
      conv(m[0], m[1], m[2], 1'b1);
    end
    cmd(16'h9002, 24);
    cmd(16'h9006, 16);
    check(ref_en, 1'b1);
    cmd(16'h9006, 24);
    check(ref_en, 1'b0);
    print_verdict();
  end
endmodule : dasi_serial_if_test
